// ---- hw/sensor_i2c_map.svh ----
// Constants of the sensor I2C target with its ready-window control.
// Included by the design file; holds definitions only.
//
// Overview of operation
// - Byte address selects word; reads advance per two
// - Words travel low byte first, then high
// - Also acknowledge own address with bit zero flipped
// - Standard I2C to 1 MHz; stretch at bytes
// - Pull ready low while window open, else release
// - Unserviced window closes after timeout, data lost
// - START disables window timeout; watchdog takes over
// - Watchdog 255 ms, every byte to own address kicks it
// - STOP closes window and releases ready line
// - With stop-ignore, window ends by command FF
// - Return EE for missing register or closed window
// - No response during auto_tuning unless reset flag
// - Configuration bit selects streaming or event reporting
// - Streaming opens window every report period
// - Event mode opens window on event or reset
// - Event mode only after reset flag cleared
// - Enabled event flags clear on read; keep reopening
// - Events: tuning error/start, power, slider, prox, touch
// - Forced request opens window after application wait
// - Read-only writes ignored unless check override set
`ifndef SENSOR_I2C_MAP_SVH
`define SENSOR_I2C_MAP_SVH

// Clock and derived time bases.
`define CLK_PERIOD_NS   20
`define MS_NS           1000000
`define MS_CYCLES_DEF   ((`MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FORCE_WAIT_NS   100000
`define FORCE_WAIT_DEF  ((`FORCE_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Millisecond limits of the window timeout and the watchdog.
`define WDOG_MS         16'h00FF
`define TIMEOUT_DEF_MS  16'h00C8
`define TIMEOUT_MIN_MS  16'h0002
`define TIMEOUT_MAX_MS  16'h00E6

// Bus codes and address map.
`define DEV_ADDR_DEF    7'h44
`define END_CMD         8'hFF
`define INVALID_BYTE    8'hEE
`define STATUS_ADDR     8'h10
`define RO_LIMIT        8'h30
`define SYSCTRL_ADDR    8'hF0
`define RST_ACK_BIT     7
`define STAT_RST_BIT    7
`define NUM_EVENTS      6

`endif

// ---- hw/sensor_i2c_pkg.sv ----
// Types shared by the sensor I2C target.
// Assumes the map header is compiled alongside.
package sensor_i2c_pkg;

   // Window control states in the core domain.
   typedef enum logic [1:0] {
      W_CLOSED = 2'b00,
      W_OPEN   = 2'b01,
      W_BUSY   = 2'b10,
      W_FORCE  = 2'b11
   } win_state_t;

   // Byte engine states in the link domain.
   typedef enum logic [2:0] {
      L_IDLE  = 3'b000,
      L_ADDR  = 3'b001,
      L_WRITE = 3'b010,
      L_READ  = 3'b011,
      L_SKIP  = 3'b100
   } link_state_t;

   // Quasi-static levels passed from core to link.
   typedef struct packed {
      logic win;
      logic blk;
      logic stop_ign;
      logic wchk_off;
   } link_cfg_t;

   // Toggle events passed from link to core.
   typedef struct packed {
      logic start;
      logic stop;
      logic endc;
      logic kick;
      logic stat_rd;
      logic rst_ack;
   } link_evt_t;

endpackage

// ---- hw/sensor_i2c_slave_window.sv ----
// Sensor I2C target: window control on REF_CLK, bit engine on LINK_CLK.
// Assumes LINK_CLK runs freely and much faster than SCL, and that the
// register store answers REG_RD on the next LINK_CLK edge.
`timescale 1ns/10ps
`include "sensor_i2c_map.svh"

module sensor_i2c_slave_window
   import sensor_i2c_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR          = `DEV_ADDR_DEF,
   parameter int         MS_CYCLES         = `MS_CYCLES_DEF,
   parameter int         FORCE_WAIT_CYCLES = `FORCE_WAIT_DEF
)
(
   input  wire logic        REF_CLK,
   input  wire logic        RESET_N,
   input  wire logic        LINK_CLK,
   input  wire logic        SCL_IN,
   output logic             SCL_OUT,
   output logic             SCL_OE,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE,
   output logic             RDY_OUT,
   output logic             RDY_OE,
   input  wire logic        STREAM_MODE,
   input  wire logic        ULP_ACTIVE,
   input  wire logic [15:0] REPORT_MS,
   input  wire logic [15:0] ULP_RATE_MS,
   input  wire logic [7:0]  AUTO_CYCLE_SEL,
   input  wire logic [15:0] TIMEOUT_MS,
   input  wire logic [5:0]  EVENT_EN,
   input  wire logic [5:0]  EVENT_IN,
   input  wire logic        TUNING_BUSY,
   input  wire logic        STOP_IGNORE,
   input  wire logic        WRITE_CHECK_OFF,
   output logic             RESET_FLAG,
   output logic             WDOG_RESET,
   output logic             REG_RD,
   output logic             REG_WR,
   output logic [7:0]       REG_ADDR,
   output logic [15:0]      REG_WDATA,
   input  wire logic [15:0] REG_RDATA,
   input  wire logic        REG_HIT
);

   localparam int MSW = $clog2(MS_CYCLES);
   localparam int FWW = $clog2(FORCE_WAIT_CYCLES + 1);

   // Zero selects the default; otherwise the value is held inside its range.
   function automatic logic [15:0] clamp_timeout(input logic [15:0] ms);
      if (ms == 16'h0000)
         return `TIMEOUT_DEF_MS;
      else if (ms < `TIMEOUT_MIN_MS)
         return `TIMEOUT_MIN_MS;
      else if (ms > `TIMEOUT_MAX_MS)
         return `TIMEOUT_MAX_MS;
      return ms;
   endfunction

   // Core domain declarations.
   win_state_t       w_state;
   win_state_t       next_w_state;
   logic [MSW-1:0]   ms_div;
   logic [15:0]      st_ms;
   logic [23:0]      per_cnt;
   logic             per_due;
   logic [FWW-1:0]   fw_cnt;
   logic [5:0]       ev_flags;
   logic             reset_flag;
   logic [7:0]       snap;
   link_cfg_t        cfg_core;
   logic [5:0]       ev_m1;
   logic [5:0]       ev_m2;
   logic [5:0]       ev_m3;

   // Link domain declarations.
   link_evt_t        lev;
   link_cfg_t        cfg_m1;
   link_cfg_t        cfg_s;
   logic             lrst_m1;
   logic             lrst_n;
   logic [1:0]       pin_m1;
   logic [1:0]       pin_s;
   logic [1:0]       pin_q;
   link_state_t      l_state;
   logic [3:0]       bitcnt;
   logic [7:0]       shreg;
   logic [7:0]       reg_addr;
   logic [7:0]       wlsb;
   logic             first_byte;
   logic             have_lsb;
   logic             ack_en;
   logic [15:0]      txw;
   logic             tx_hi;
   logic             tx_ready;
   logic             rd_pend;
   logic             stretch;

   // Core decode.
   wire link_evt_t   evp       = link_evt_t'(ev_m2 ^ ev_m3);
   wire              ms_tick   = (ms_div == MSW'(MS_CYCLES - 1));
   wire [15:0]       tmo_ms    = clamp_timeout(TIMEOUT_MS);
   wire              tmo_hit   = (st_ms >= tmo_ms);
   wire              wd_exp    = (st_ms >= `WDOG_MS);
   wire              fw_done   = (fw_cnt == FWW'(FORCE_WAIT_CYCLES));
   wire [5:0]        new_ev    = EVENT_IN & EVENT_EN;
   wire              ev_mode   = ~STREAM_MODE & ~reset_flag;
   wire [23:0]       ulp_per   = {16'h0000, AUTO_CYCLE_SEL} * {8'h00, ULP_RATE_MS};
   wire [23:0]       period_ms = ULP_ACTIVE ? ulp_per : {8'h00, REPORT_MS};
   wire              open_req  = ev_mode ? (|ev_flags) : per_due;
   wire              entering  = (next_w_state == W_OPEN) && (w_state != W_OPEN);

   // Window sequencing; a START while closed is taken as a forced request.
   always_comb
   begin
      next_w_state = w_state;
      case (w_state)
         W_CLOSED:
            if (evp.start)
               next_w_state = W_FORCE;
            else if (open_req)
               next_w_state = W_OPEN;
         W_FORCE:
            if (fw_done)
               next_w_state = W_OPEN;
         W_OPEN:
            if (evp.start)
               next_w_state = W_BUSY;
            else if (evp.stop || evp.endc || tmo_hit)
               next_w_state = W_CLOSED;
         W_BUSY:
            if (evp.stop || evp.endc || wd_exp)
               next_w_state = W_CLOSED;
         default:
            next_w_state = W_CLOSED;
      endcase
   end

   // Toggle synchronisers; the first stage feeds only the second.
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         ev_m1 <= 6'h00;
         ev_m2 <= 6'h00;
         ev_m3 <= 6'h00;
      end
      else
      begin
         ev_m1 <= lev;
         ev_m2 <= ev_m1;
         ev_m3 <= ev_m2;
      end
   end

   // Millisecond base, state timer and report period.
   // The timer is restarted on state change and on a byte kick while the window is busy.
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         ms_div  <= '0;
         st_ms   <= 16'h0000;
         per_cnt <= 24'h000000;
         per_due <= 1'b0;
         fw_cnt  <= '0;
      end
      else
      begin
         ms_div  <= ms_tick ? '0 : ms_div + 1'b1;
         if ((w_state != next_w_state) || (evp.kick && w_state == W_BUSY))
            st_ms <= 16'h0000;
         else if (ms_tick && st_ms != 16'hFFFF)
            st_ms <= st_ms + 16'h0001;
         if (ms_tick)
            per_cnt <= (per_cnt + 24'h000001 >= period_ms) ? 24'h000000 : per_cnt + 24'h000001;
         if (ms_tick && per_cnt + 24'h000001 >= period_ms)
            per_due <= 1'b1;
         else if (entering)
            per_due <= 1'b0;
         fw_cnt  <= (w_state == W_FORCE) ? fw_cnt + 1'b1 : '0;
      end
   end

   // Window state, ready line, watchdog pulse and the status snapshot.
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         w_state    <= W_CLOSED;
         RDY_OE     <= 1'b0;
         RDY_OUT    <= 1'b0;
         WDOG_RESET <= 1'b0;
         snap       <= 8'h00;
         cfg_core   <= '0;
      end
      else
      begin
         w_state    <= next_w_state;
         RDY_OE     <= (next_w_state == W_OPEN) || (next_w_state == W_BUSY);
         RDY_OUT    <= 1'b0;
         WDOG_RESET <= (w_state == W_BUSY) && wd_exp && !evp.stop && !evp.endc;
         if (entering)
            snap <= {reset_flag, 1'b0, ev_flags};
         cfg_core   <= '{win: (next_w_state == W_OPEN) || (next_w_state == W_BUSY),
                         blk: TUNING_BUSY & ~reset_flag,
                         stop_ign: STOP_IGNORE,
                         wchk_off: WRITE_CHECK_OFF};
      end
   end

   // Sticky flags: a new event in the clearing cycle survives.
   always_ff @(posedge REF_CLK)
   begin
      if (!RESET_N)
      begin
         ev_flags   <= 6'h00;
         reset_flag <= 1'b1;
         RESET_FLAG <= 1'b1;
      end
      else
      begin
         ev_flags   <= (evp.stat_rd ? (ev_flags & ~snap[5:0]) : ev_flags) | new_ev;
         reset_flag <= reset_flag & ~evp.rst_ack;
         RESET_FLAG <= reset_flag & ~evp.rst_ack;
      end
   end

   // Link decode.
   wire       scl_s     = pin_s[1];
   wire       sda_s     = pin_s[0];
   wire       scl_rise  = scl_s & ~pin_q[1];
   wire       scl_fall  = ~scl_s & pin_q[1];
   wire       start_c   = scl_s & pin_q[1] & ~sda_s & pin_q[0];
   wire       stop_c    = scl_s & pin_q[1] & sda_s & ~pin_q[0];
   wire [7:0] rx_byte   = {shreg[6:0], sda_s};
   wire       byte_done = scl_rise && (bitcnt == 4'h7);
   wire       addr_hit  = (rx_byte[7:1] == DEV_ADDR) ||
                          (rx_byte[7:1] == {DEV_ADDR[6:1], ~DEV_ADDR[0]});
   wire [7:0] tx_byte   = tx_hi ? txw[15:8] : txw[7:0];
   wire       tx_bit    = tx_byte[3'(3'h7 - bitcnt[2:0])];
   wire [7:0] next_addr = reg_addr + 8'h01;
   wire       wr_ok     = cfg_s.win && (reg_addr >= `RO_LIMIT || cfg_s.wchk_off);
   wire [15:0] rd_word  = !cfg_s.win ? {`INVALID_BYTE, `INVALID_BYTE} :
                          (REG_ADDR == `STATUS_ADDR) ? {8'h00, snap} :
                          REG_HIT ? REG_RDATA : {`INVALID_BYTE, `INVALID_BYTE};

   // Link reset, configuration and pin synchronisers.
   always_ff @(posedge LINK_CLK)
   begin
      lrst_m1 <= RESET_N;
      lrst_n  <= lrst_m1;
      cfg_m1  <= cfg_core;
      cfg_s   <= cfg_m1;
      pin_m1  <= {SCL_IN, SDA_IN};
      pin_s   <= pin_m1;
      pin_q   <= pin_s;
   end

   // Bit and byte engine; SCL is held low at a byte boundary until data is ready.
   always_ff @(posedge LINK_CLK)
   begin
      if (!lrst_n)
      begin
         l_state <= L_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         reg_addr <= 8'h00;
         wlsb <= 8'h00;
         first_byte <= 1'b0;
         have_lsb <= 1'b0;
         ack_en <= 1'b0;
         txw <= 16'h0000;
         tx_hi <= 1'b0;
         tx_ready <= 1'b0;
         rd_pend <= 1'b0;
         stretch <= 1'b0;
         lev <= '0;
         SDA_OE <= 1'b0;
         SCL_OE <= 1'b0;
         SDA_OUT <= 1'b0;
         SCL_OUT <= 1'b0;
         REG_RD <= 1'b0;
         REG_WR <= 1'b0;
         REG_ADDR <= 8'h00;
         REG_WDATA <= 16'h0000;
      end
      else
      begin
         REG_RD <= 1'b0;
         REG_WR <= 1'b0;
         if (rd_pend)
         begin
            txw      <= rd_word;
            tx_ready <= 1'b1;
            rd_pend  <= 1'b0;
            if (cfg_s.win && REG_ADDR == `STATUS_ADDR)
               lev.stat_rd <= ~lev.stat_rd;
         end
         if (stretch && tx_ready)
         begin
            SDA_OE  <= ~tx_bit;
            SCL_OE  <= 1'b0;
            stretch <= 1'b0;
            bitcnt  <= 4'h0;
         end
         if (start_c)
         begin
            l_state   <= L_ADDR;
            bitcnt    <= 4'h0;
            SDA_OE    <= 1'b0;
            SCL_OE    <= 1'b0;
            stretch   <= 1'b0;
            lev.start <= ~lev.start;
         end
         else if (stop_c)
         begin
            l_state <= L_IDLE;
            SDA_OE  <= 1'b0;
            SCL_OE  <= 1'b0;
            stretch <= 1'b0;
            if (!cfg_s.stop_ign)
               lev.stop <= ~lev.stop;
         end
         else if (l_state != L_IDLE && scl_rise)
         begin
            shreg  <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == 4'h8 && l_state == L_READ && !ack_en) // Own address ack is skipped.
            begin
               if (sda_s)
                  l_state <= L_SKIP;
               else if (tx_hi)
               begin
                  tx_hi    <= 1'b0;
                  reg_addr <= next_addr;
                  REG_ADDR <= next_addr;
                  REG_RD   <= 1'b1;
                  rd_pend  <= 1'b1;
                  tx_ready <= 1'b0;
               end
               else
                  tx_hi <= 1'b1;
            end
            if (byte_done)
            begin
               ack_en <= 1'b0;
               case (l_state)
                  L_ADDR:
                     if (addr_hit && !cfg_s.blk)
                     begin
                        ack_en   <= 1'b1;
                        lev.kick <= ~lev.kick;
                        if (rx_byte[0])
                        begin
                           l_state  <= L_READ;
                           tx_hi    <= 1'b0;
                           REG_ADDR <= reg_addr;
                           REG_RD   <= 1'b1;
                           rd_pend  <= 1'b1;
                           tx_ready <= 1'b0;
                        end
                        else
                        begin
                           l_state    <= L_WRITE;
                           first_byte <= 1'b1;
                           have_lsb   <= 1'b0;
                        end
                     end
                     else
                        l_state <= L_SKIP;
                  L_WRITE:
                  begin
                     ack_en   <= 1'b1;
                     lev.kick <= ~lev.kick;
                     if (first_byte)
                     begin
                        first_byte <= 1'b0;
                        reg_addr   <= rx_byte;
                        if (rx_byte == `END_CMD)
                           lev.endc <= ~lev.endc;
                     end
                     else if (!have_lsb)
                     begin
                        wlsb     <= rx_byte;
                        have_lsb <= 1'b1;
                     end
                     else
                     begin
                        have_lsb  <= 1'b0;
                        reg_addr  <= next_addr;
                        REG_ADDR  <= reg_addr;
                        REG_WDATA <= {rx_byte, wlsb};
                        REG_WR    <= wr_ok;
                        if (cfg_s.win && reg_addr == `SYSCTRL_ADDR && wlsb[`RST_ACK_BIT])
                           lev.rst_ack <= ~lev.rst_ack;
                     end
                  end
                  L_READ:
                     lev.kick <= ~lev.kick;
                  default:
                     ack_en <= 1'b0;
               endcase
            end
         end
         else if (l_state != L_IDLE && scl_fall)
         begin
            if (bitcnt == 4'h8)
               SDA_OE <= ack_en;
            else if (bitcnt == 4'h9)
            begin
               SDA_OE <= 1'b0;
               bitcnt <= 4'h0;
               if (l_state == L_READ)
               begin
                  if (tx_ready)
                     SDA_OE <= ~tx_bit;
                  else
                  begin
                     SCL_OE  <= 1'b1;
                     stretch <= 1'b1;
                     bitcnt  <= 4'h9;
                  end
               end
            end
            else if (l_state == L_READ)
               SDA_OE <= ~tx_bit;
         end
      end
   end

   // Core domain checks.
   rdy_follow_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_OPEN) |-> RDY_OE ##1 (RDY_OE == (w_state != W_CLOSED && w_state != W_FORCE)))
      else $error("ready line does not follow the window");
   tmo_close_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_OPEN && !evp.start && tmo_hit) |=> (w_state == W_CLOSED) && !RDY_OE)
      else $error("window timeout did not close the window");
   busy_hold_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_BUSY && !evp.stop && !evp.endc && !wd_exp) |=> (w_state == W_BUSY))
      else $error("busy window left without stop or watchdog");
   wdog_fire_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_BUSY && wd_exp && !evp.stop && !evp.endc)
      |=> WDOG_RESET && (w_state == W_CLOSED) ##1 !WDOG_RESET)
      else $error("watchdog expiry not signalled as one pulse");
   stop_close_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_BUSY && evp.stop) |=> (w_state == W_CLOSED))
      else $error("stop did not close the window");
   flag_set_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (|new_ev) |=> ((ev_flags & $past(new_ev)) == $past(new_ev)))
      else $error("event lost against a clear");
   event_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_CLOSED && ev_mode && ev_flags == 6'h00 && !evp.start)
      |=> (w_state != W_OPEN))
      else $error("event mode opened a window without an event");
   force_open_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_FORCE && fw_done) |=> (w_state == W_OPEN) && RDY_OE)
      else $error("forced request did not open a window");

   // Link domain checks.
   invalid_rd_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
      (rd_pend && !cfg_s.win) |=> (txw == {`INVALID_BYTE, `INVALID_BYTE}) && tx_ready)
      else $error("closed window read did not return the invalid code");
   ro_write_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
      REG_WR |-> (REG_ADDR >= `RO_LIMIT || $past(cfg_s.wchk_off)))
      else $error("write reached a read-only register");
   tune_nack_a: assert property (@(posedge LINK_CLK) disable iff (!lrst_n)
      (l_state == L_ADDR && byte_done && !start_c && !stop_c && cfg_s.blk)
      |=> (l_state == L_SKIP) && !ack_en)
      else $error("address acknowledged during auto_tuning");

   // Main scenarios.
   win_busy_c: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_OPEN) ##1 (w_state == W_BUSY));
   win_tmo_c: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_OPEN && tmo_hit) ##1 (w_state == W_CLOSED));
   force_c: cover property (@(posedge REF_CLK) disable iff (!RESET_N)
      (w_state == W_FORCE) ##1 (w_state == W_OPEN));
   stretch_c: cover property (@(posedge LINK_CLK) disable iff (!lrst_n)
      SCL_OE ##1 !SCL_OE);

endmodule

// ---- tb/i2c_host_model.sv ----
// Behavioural I2C host that clocks the bus from tasks.
// Assumes the bench resolves both open-drain wires with pull-ups.
`timescale 1ns/10ps
module i2c_host_model
(
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe
);
   // Half a bit time; two of them keep SCL at or below 1 MHz.
   localparam int H = 500;
   // One bit; waiting for SCL to rise lets the target stretch the clock.
   task automatic bit_io(input logic b, output logic r);
      sda_oe = ~b;
      #H scl_oe = 1'b0;
      wait (scl);
      #H r = sda;
      scl_oe = 1'b1;
   endtask
   // Also serves as a repeated start while SCL is held low.
   task automatic start();
      sda_oe = 1'b0;
      #H scl_oe = 1'b0;
      wait (scl);
      #H sda_oe = 1'b1;
      #H scl_oe = 1'b1;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #H scl_oe = 1'b0;
      wait (scl);
      #H sda_oe = 1'b0;
      #H;
   endtask
   // Sending FF releases SDA so the target can answer a read.
   task automatic xfer(input logic [7:0] tx, input logic m, output logic [7:0] rx,
                       output logic a);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(m, a);
   endtask
   initial
   begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end
endmodule

// ---- tb/tb.sv ----
// Bench for the sensor I2C target with a host model on the bus.
// Assumes design, package and header are compiled before it.
`timescale 1ns/10ps
module tb;
   logic        ref_clk, link_clk, reset_n = 0, busy = 0, wchk = 0, ack, rf;
   logic        stream = 1, stop_ign = 0;
   logic [15:0] tmo = 16'h0032, rep = 16'h0064, wd;
   logic [5:0]  ev = 6'h3F;
   logic        s_oe, d_oe, hs, hd, rdy, wr_s;
   logic [7:0]  ra, rx, wa;
   int          fails = 0, samples_checked = 0, wn = 0;
   wire scl = ~(s_oe | hs);
   wire sda = ~(d_oe | hd);
   sensor_i2c_slave_window #(.MS_CYCLES(50), .FORCE_WAIT_CYCLES(5)) i_sensor_i2c_slave_window (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .LINK_CLK(link_clk), .SCL_IN(scl), .SCL_OUT(),
      .SCL_OE(s_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(d_oe), .RDY_OUT(), .RDY_OE(rdy),
      .STREAM_MODE(stream), .ULP_ACTIVE(1'b0), .REPORT_MS(rep), .ULP_RATE_MS(16'h0001),
      .AUTO_CYCLE_SEL(8'h01), .TIMEOUT_MS(tmo), .EVENT_EN(ev), .EVENT_IN(ev),
      .TUNING_BUSY(busy), .STOP_IGNORE(stop_ign), .WRITE_CHECK_OFF(wchk), .RESET_FLAG(rf),
      .WDOG_RESET(), .REG_RD(), .REG_WR(wr_s), .REG_ADDR(ra), .REG_WDATA(wd),
      .REG_RDATA({ra, ~ra}), .REG_HIT(ra != 8'h20));
   i2c_host_model i_i2c_host_model (.scl(scl), .sda(sda), .scl_oe(hs), .sda_oe(hd));
   // Two unrelated clocks; the link one is offset so edges never line up.
   initial
   begin
      ref_clk = 0;
      forever #10 ref_clk = ~ref_clk;
   end
   initial
   begin
      link_clk = 0;
      #3.7;
      forever #7.5 link_clk = ~link_clk;
   end
   // Records every store write so the scenarios can judge them later.
   always @(posedge link_clk)
      if (wr_s === 1'b1)
      begin
         wn <= wn + 1;
         wa <= ra;
      end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] b, input logic a);
      i_i2c_host_model.xfer(b, 1'b1, rx, ack);
      chk("ack", 16'(a), 16'(ack));
   endtask
   task automatic rd(input logic [7:0] e, input logic m);
      i_i2c_host_model.xfer(8'hFF, m, rx, ack);
      chk("rd", 16'(e), 16'(rx));
   endtask
   // Bounded wait for the ready line, then a START from the host.
   task automatic win();
      for (int i = 0; i < 6000 && rdy !== 1'b1; i++)
         @(negedge ref_clk);
      chk("win", 1, 16'(rdy));
      i_i2c_host_model.start();
   endtask
   task automatic sc_write();
      win();
      wr(8'h88, 0);
      wr(8'h2F, 0);
      for (int i = 0; i < 4; i++)
         wr(8'(32'hC35A2211 >> 8 * i), 0);
      i_i2c_host_model.stop();
      chk("wn", 1, 16'(wn));
      chk("wa", 16'h0030, 16'(wa));
      chk("wd", 16'hC35A, wd);
      repeat (20) @(negedge ref_clk);
      chk("rdy", 0, 16'(rdy));
   endtask
   task automatic sc_read();
      win();
      wr(8'h88, 0);
      wr(8'h1F, 0);
      i_i2c_host_model.start();
      wr(8'h89, 0);
      rd(8'hE0, 0);
      rd(8'h1F, 0);
      rd(8'hEE, 0);
      rd(8'hEE, 1);
      i_i2c_host_model.stop();
   endtask
   // Debug address during tuning with the flag set, a forced window, an override write.
   task automatic sc_force();
      @(negedge ref_clk);
      busy = 1;
      wchk = 1;
      win();
      for (int i = 0; i < 4; i++)
         wr(8'(32'h1234128A >> 8 * i), 0);
      i_i2c_host_model.stop();
      chk("wa", 16'h0012, 16'(wa));
      @(negedge ref_clk);
      busy = 0;
      repeat (20) @(negedge ref_clk);
      i_i2c_host_model.start();
      wr(8'h8C, 1);
      chk("force", 1, 16'(rdy));
      i_i2c_host_model.stop();
   endtask
   task automatic sc_timeout();
      repeat (20) @(negedge ref_clk);
      tmo = 16'h0002;
      rep = 16'h0028;
      for (int i = 0; i < 3000 && rdy !== 1'b1; i++)
         @(negedge ref_clk);
      repeat (45) @(negedge ref_clk);
      chk("open", 1, 16'(rdy));
      repeat (105) @(negedge ref_clk);
      chk("shut", 0, 16'(rdy));
   endtask
   // Clears the reset flag, then event mode, a status read and the end command.
   task automatic sc_event();
      tmo = 16'h0000;
      stream = 0;
      win();
      wr(8'h88, 0);
      for (int i = 0; i < 3; i++)
         wr(8'(24'h0080F0 >> 8 * i), 0);
      i_i2c_host_model.stop();
      repeat (20) @(negedge ref_clk);
      chk("rf", 0, 16'(rf));
      chk("idle", 0, 16'(rdy));
      ev = 6'h10;
      stop_ign = 1;
      @(negedge ref_clk);
      ev = 6'h00;
      win();
      wr(8'h88, 0);
      wr(8'h10, 0);
      i_i2c_host_model.start();
      wr(8'h89, 0);
      rd(8'h10, 0);
      rd(8'h00, 1);
      i_i2c_host_model.stop();
      repeat (20) @(negedge ref_clk);
      chk("kept", 1, 16'(rdy));
      busy = 1;
      i_i2c_host_model.start();
      wr(8'h88, 1);
      @(negedge ref_clk);
      busy = 0;
      i_i2c_host_model.start();
      wr(8'h88, 0);
      wr(8'hFF, 0);
      i_i2c_host_model.stop();
      repeat (20) @(negedge ref_clk);
      chk("ended", 0, 16'(rdy));
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(negedge ref_clk);
      reset_n = 1;
      ev = 6'h00;
      chk("flag", 1, 16'(rf));
      sc_write();
      sc_read();
      sc_force();
      sc_timeout();
      sc_event();
      conclude();
   end
   // Cuts a hang short well after the expected run length.
   initial
   begin
      #2000000;
      fails++;
      conclude();
   end
endmodule
